/* File: eip_sfr_bank.sv */
// Behaviour
// RULE_01: Port-0 disable bit one turns pin input off
// RULE_02: Top-priority bit 5 lifts brake interrupt
// RULE_03: Top-priority bit 4 lifts watchdog interrupt
// RULE_04: Top-priority bits 3..0 lift cmp2,cmp1,keypad,i2c
// RULE_05: Priority bit 5 raises brake interrupt level
// RULE_06: Priority bits 4..0 raise remaining sources
// RULE_07: Request passes only when enabled; bits 7:6 reserved
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module eip_sfr_bank (
    input wire logic clk_i, // Core clock, 200 MHz
    input wire logic rst_i, // Async reset, high
    input wire logic hsel_i, // AHB select
    input wire logic [31:0] haddr_i, // AHB address
    input wire logic [1:0] htrans_i, // AHB transfer type
    input wire logic hwrite_i, // AHB write
    input wire logic [2:0] hsize_i, // AHB size, word only
    input wire logic [eip_pkg::DATA_W-1:0] hwdata_i, // AHB write data
    input wire logic hready_i, // AHB bus ready
    output logic hreadyout_o, // AHB slave ready
    output logic [eip_pkg::DATA_W-1:0] hrdata_o, // AHB read data
    output logic hresp_o, // AHB response
    input wire logic [eip_pkg::NUM_SRC-1:0] src_req_i, // Raw requests
    output logic [eip_pkg::NUM_SRC-1:0] irq_req_o, // Gated requests
    output logic [eip_pkg::NUM_SRC*eip_pkg::LVL_W-1:0] irq_level_o, // Levels
    input wire logic [eip_pkg::REG_W-1:0] port0_pin_i, // Port-0 pads
    output logic [eip_pkg::REG_W-1:0] port0_data_o, // Gated pad data
    output logic [eip_pkg::REG_W-1:0] port0_input_off_o, // Buffer disables
    output logic [eip_pkg::REG_W-1:0] acc_o, // Accumulator
    output logic [eip_pkg::REG_W-1:0] second_acc_o // Second accumulator
);
    import eip_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Bus pipeline state
    logic wr_pend_reg; // Write data phase pending
    logic wr_pend_next;
    logic [7:0] wr_idx_reg; // Index of pending write
    logic [7:0] wr_idx_next;
    logic [DATA_W-1:0] hrdata_reg; // Read data register
    logic [DATA_W-1:0] hrdata_next;

    // Register file
    logic [REG_W-1:0] acc_reg; // accumulator
    logic [REG_W-1:0] acc_next;
    logic [REG_W-1:0] second_acc_reg; // second_accumulator
    logic [REG_W-1:0] second_acc_next;
    logic [REG_W-1:0] enable_reg; // extended_irq_enable
    logic [REG_W-1:0] enable_next;
    logic [REG_W-1:0] port0_input_off_reg; // port0_input_disable
    logic [REG_W-1:0] port0_input_off_next;
    logic [REG_W-1:0] top_prio_reg; // extended_irq_top_priority
    logic [REG_W-1:0] top_prio_next;
    logic [REG_W-1:0] prio_reg; // extended_irq_priority
    logic [REG_W-1:0] prio_next;

    // Port-0 gated input
    logic [REG_W-1:0] port0_data_reg; // Pad data after buffer gate
    logic [REG_W-1:0] port0_data_next;

    // Decode helpers
    logic addr_phase; // Valid address phase this cycle
    logic addr_hit; // Upper address bits clear
    logic [7:0] addr_idx; // Index from haddr
    logic [REG_W-1:0] wbyte; // Write data low byte
    logic [REG_W-1:0] rd_byte; // Selected read value

    ////////////////////////////////////////////////////////////////////////
    // Address phase decode
    // hsize is not decoded: any access counts as a whole word
    always_comb begin
        addr_phase = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
        addr_hit = (haddr_i[ADDR_MSB:IDX_MSB+1] == '0);
        addr_idx = haddr_i[IDX_MSB:IDX_LSB];
        wbyte = hwdata_i[REG_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus pipeline: capture the write, build read data early
    always_comb begin
        wr_pend_next = addr_phase & hwrite_i & addr_hit;
        wr_idx_next = addr_idx;
        hrdata_next = hrdata_reg;
        rd_byte = '0;
        // Unmapped indices read as zero
        unique case (addr_idx)
            IDX_ACC: rd_byte = acc_next;
            IDX_ENABLE: rd_byte = enable_next & SRC_MASK; // RULE_07
            IDX_PENDING: rd_byte = {2'h0, irq_req_o};
            IDX_SECOND_ACC: rd_byte = second_acc_next;
            IDX_P0_OFF: rd_byte = port0_input_off_next;
            IDX_TOP_PRIO: rd_byte = top_prio_next & SRC_MASK; // RULE_07
            IDX_PRIO: rd_byte = prio_next & SRC_MASK; // RULE_07
            default: rd_byte = '0;
        endcase
        // The _next values forward a write still in its data phase
        if (addr_phase & ~hwrite_i) begin
            hrdata_next = addr_hit ? {{(DATA_W-REG_W){1'b0}}, rd_byte} : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes in the data phase
    always_comb begin
        acc_next = acc_reg;
        second_acc_next = second_acc_reg;
        enable_next = enable_reg;
        port0_input_off_next = port0_input_off_reg;
        top_prio_next = top_prio_reg;
        prio_next = prio_reg;
        if (wr_pend_reg) begin
            // Unmapped index: write dropped, still OKAY
            unique case (wr_idx_reg)
                IDX_ACC: acc_next = wbyte;
                IDX_SECOND_ACC: second_acc_next = wbyte;
                // Reserved bits 7:6 of the source registers never store
                IDX_ENABLE: enable_next = wbyte & SRC_MASK; // RULE_07
                IDX_P0_OFF: port0_input_off_next = wbyte; // RULE_01
                IDX_TOP_PRIO: top_prio_next = wbyte & SRC_MASK; // RULE_03
                IDX_PRIO: prio_next = wbyte & SRC_MASK; // RULE_05
                default: acc_next = acc_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port-0 input buffer gate
    // Pad data is registered, so software sees it one cycle late
    always_comb begin
        // A disabled buffer reads low instead of following the pad
        port0_data_next = port0_pin_i & ~port0_input_off_reg; // RULE_01
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= '0;
            hrdata_reg <= '0;
            acc_reg <= REG_RST;
            second_acc_reg <= REG_RST;
            enable_reg <= REG_RST;
            port0_input_off_reg <= REG_RST;
            top_prio_reg <= REG_RST;
            prio_reg <= REG_RST;
            port0_data_reg <= REG_RST;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            hrdata_reg <= hrdata_next;
            acc_reg <= acc_next;
            second_acc_reg <= second_acc_next;
            enable_reg <= enable_next;
            port0_input_off_reg <= port0_input_off_next;
            top_prio_reg <= top_prio_next;
            prio_reg <= prio_next;
            port0_data_reg <= port0_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-source gate and level, one lane each
    // Arbitration between sources stays outside, in the core
    generate
        for (genvar i = 0; i < NUM_SRC; i++) begin : g_lane
            eip_irq_lane u_lane (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .src_req_i(src_req_i[i]),
                .enable_i(enable_reg[i]), // RULE_07
                .top_i(top_prio_reg[i]), // RULE_04
                .high_i(prio_reg[i]), // RULE_06
                .req_o(irq_req_o[i]),
                .level_o(irq_level_o[i*LVL_W +: LVL_W])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs; zero wait states, so ready stays high
    // No error response: stray addresses are quietly ignored
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;
    assign hrdata_o = hrdata_reg;
    assign port0_input_off_o = port0_input_off_reg;
    assign port0_data_o = port0_data_reg;
    assign acc_o = acc_reg;
    assign second_acc_o = second_acc_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Index-matched data phase write
    logic wr_top; // Write to top priority
    logic wr_prio; // Write to priority
    logic wr_p0; // Write to port-0 disable
    logic wr_en; // Write to enable
    assign wr_top = wr_pend_reg && (wr_idx_reg == IDX_TOP_PRIO);
    assign wr_prio = wr_pend_reg && (wr_idx_reg == IDX_PRIO);
    assign wr_p0 = wr_pend_reg && (wr_idx_reg == IDX_P0_OFF);
    assign wr_en = wr_pend_reg && (wr_idx_reg == IDX_ENABLE);

    chk_p0_off_write: assert property ( // RULE_01
        wr_p0 |=> port0_input_off_o == $past(hwdata_i[REG_W-1:0]))
        else $error("port-0 disable write not stored");

    // Skip the edge that releases reset: the pad flop was still cleared
    chk_p0_gate: assert property ( // RULE_01
        !rst_i |=> port0_data_o ==
            ($past(port0_pin_i) & ~$past(port0_input_off_o)))
        else $error("port-0 pad gate wrong");

    chk_brake_top: assert property ( // RULE_02
        wr_top |-> ##2
        irq_level_o[BRAKE_POS*LVL_W+LVL_TOP_OFS] == $past(hwdata_i[5], 2))
        else $error("brake top level not applied");

    chk_wdog_top: assert property ( // RULE_03
        wr_top |-> ##2
        irq_level_o[WDOG_POS*LVL_W+LVL_TOP_OFS] == $past(hwdata_i[4], 2))
        else $error("watchdog top level not applied");

    chk_low_top: assert property ( // RULE_04
        wr_top |-> ##2
        {irq_level_o[CMP2_POS*LVL_W+LVL_TOP_OFS],
         irq_level_o[CMP1_POS*LVL_W+LVL_TOP_OFS],
         irq_level_o[KEYPAD_POS*LVL_W+LVL_TOP_OFS],
         irq_level_o[I2C_POS*LVL_W+LVL_TOP_OFS]} == $past(hwdata_i[3:0], 2))
        else $error("top level of low sources wrong");

    chk_brake_high: assert property ( // RULE_05
        wr_prio |-> ##2
        irq_level_o[BRAKE_POS*LVL_W+LVL_HIGH_OFS] == $past(hwdata_i[5], 2))
        else $error("brake high level not applied");

    chk_other_high: assert property ( // RULE_06
        wr_prio |-> ##2
        {irq_level_o[WDOG_POS*LVL_W+LVL_HIGH_OFS],
         irq_level_o[CMP2_POS*LVL_W+LVL_HIGH_OFS],
         irq_level_o[CMP1_POS*LVL_W+LVL_HIGH_OFS],
         irq_level_o[KEYPAD_POS*LVL_W+LVL_HIGH_OFS],
         irq_level_o[I2C_POS*LVL_W+LVL_HIGH_OFS]} == $past(hwdata_i[4:0], 2))
        else $error("high level of other sources wrong");

    chk_req_gated: assert property ( // RULE_07
        !rst_i |=> irq_req_o == ($past(src_req_i) &
            $past(enable_reg[NUM_SRC-1:0])))
        else $error("request passed while disabled");

    chk_enable_reserved: assert property ( // RULE_07
        wr_en |=> enable_reg[REG_W-1:NUM_SRC] == '0 &&
            enable_reg[NUM_SRC-1:0] == $past(hwdata_i[NUM_SRC-1:0]))
        else $error("enable write or reserved bits wrong");

    // Reserved bits 7:6 never hold a one in any source register
    chk_reserved_zero: assert property ( // RULE_07
        enable_reg[REG_W-1:NUM_SRC] == '0 &&
        top_prio_reg[REG_W-1:NUM_SRC] == '0 &&
        prio_reg[REG_W-1:NUM_SRC] == '0)
        else $error("reserved source bits set");

    // Read of the top priority register with no write in flight
    logic rd_top; // Read address phase on top priority
    assign rd_top = addr_phase && !hwrite_i && addr_hit &&
        (addr_idx == IDX_TOP_PRIO) && !wr_pend_reg;

    chk_top_read: assert property ( // RULE_07
        rd_top |=> hrdata_o[REG_W-1:0] ==
            $past(top_prio_reg & SRC_MASK) &&
            hrdata_o[DATA_W-1:REG_W] == '0)
        else $error("top priority read wrong");

    // Read of the port-0 disable register with no write in flight
    logic rd_p0; // Read address phase on port-0 disable
    assign rd_p0 = addr_phase && !hwrite_i && addr_hit &&
        (addr_idx == IDX_P0_OFF) && !wr_pend_reg;

    chk_p0_read: assert property ( // RULE_01
        rd_p0 |=> hrdata_o == {{(DATA_W-REG_W){1'b0}},
            $past(port0_input_off_o)})
        else $error("port-0 disable read wrong");

    // The i2c level pair trails its two register bits by one cycle
    chk_level_follow: assert property ( // RULE_04
        !rst_i |=> irq_level_o[I2C_POS*LVL_W+LVL_TOP_OFS] ==
            $past(top_prio_reg[I2C_POS]) &&
            irq_level_o[I2C_POS*LVL_W+LVL_HIGH_OFS] ==
            $past(prio_reg[I2C_POS]))
        else $error("i2c level does not follow registers");

    cov_top_write: cover property (wr_top ##2 irq_level_o != '0);
    cov_req_pass: cover property (wr_en ##2 irq_req_o != '0);
    cov_p0_off: cover property (wr_p0 ##1 port0_input_off_o == 8'hff);
    cov_read: cover property (addr_phase && !hwrite_i ##1 hrdata_o != '0);
    cov_pending_read: cover property (addr_phase && !hwrite_i &&
        addr_idx == IDX_PENDING ##1 hrdata_o != '0);

endmodule : eip_sfr_bank

`default_nettype wire

/* File: eip_pkg.sv */
package eip_pkg;

    // Bus and register widths
    localparam int unsigned DATA_W = 32; // AHB data width
    localparam int unsigned REG_W = 8; // Register width
    localparam int unsigned NUM_SRC = 6; // Extended interrupt sources
    localparam int unsigned LVL_W = 2; // Level bits per source

    // Register indices; byte address is index times four
    localparam logic [7:0] IDX_ACC = 8'he0; // accumulator
    localparam logic [7:0] IDX_ENABLE = 8'he8; // extended_irq_enable
    localparam logic [7:0] IDX_PENDING = 8'he9; // Gated request status
    localparam logic [7:0] IDX_SECOND_ACC = 8'hf0; // second_accumulator
    localparam logic [7:0] IDX_P0_OFF = 8'hf6; // port0_input_disable
    localparam logic [7:0] IDX_TOP_PRIO = 8'hf7; // extended_irq_top_priority
    localparam logic [7:0] IDX_PRIO = 8'hf8; // extended_irq_priority

    // Address split: word offset bits and index field
    localparam int unsigned IDX_LSB = 2; // Lowest index bit in haddr
    localparam int unsigned IDX_MSB = 9; // Highest index bit in haddr
    localparam int unsigned ADDR_MSB = 31; // Top haddr bit

    // Source bit positions, shared by enable and both priority registers
    localparam int unsigned I2C_POS = 0; // i2c_irq_*
    localparam int unsigned KEYPAD_POS = 1; // keypad_irq_*
    localparam int unsigned CMP1_POS = 2; // cmp1_irq_*
    localparam int unsigned CMP2_POS = 3; // cmp2_irq_*
    localparam int unsigned WDOG_POS = 4; // wdog_irq_*
    localparam int unsigned BRAKE_POS = 5; // brake_irq_*

    // Writable bits of the source registers; bits 7 and 6 reserved
    localparam logic [7:0] SRC_MASK = 8'h3f;

    // Reset value of every register
    localparam logic [7:0] REG_RST = 8'h00;

    // Position of each flag inside a source's level pair
    localparam int unsigned LVL_HIGH_OFS = 0; // From extended_irq_priority
    localparam int unsigned LVL_TOP_OFS = 1; // From top priority register

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // Start of transfer
    localparam logic HRESP_OKAY = 1'h0; // Only response given

endpackage : eip_pkg

/* File: eip_irq_lane.sv */
`timescale 1ns/10ps
`default_nettype none

// One extended source: enable gate and priority level flops
module eip_irq_lane (
    input wire logic clk_i, // Core clock
    input wire logic rst_i, // Async reset, high
    input wire logic src_req_i, // Raw request from source
    input wire logic enable_i, // Enable bit
    input wire logic top_i, // Top priority bit
    input wire logic high_i, // Higher priority bit
    output logic req_o, // Gated request
    output logic [eip_pkg::LVL_W-1:0] level_o // {top, high}
);
    import eip_pkg::*;

    logic req_reg; // Gated request
    logic req_next; // Next gated request
    logic [LVL_W-1:0] level_reg; // Level pair
    logic [LVL_W-1:0] level_next; // Next level pair

    ////////////////////////////////////////////////////////////////////////
    // Gate and level
    always_comb begin
        // Request passes only while enabled
        req_next = src_req_i & enable_i; // RULE_07
        level_next = '0;
        // Top flag outranks the high flag at the arbiter
        level_next[LVL_TOP_OFS] = top_i; // RULE_02
        level_next[LVL_HIGH_OFS] = high_i; // RULE_05
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_reg <= 1'b0;
            level_reg <= '0;
        end else begin
            req_reg <= req_next;
            level_reg <= level_next;
        end
    end

    assign req_o = req_reg;
    assign level_o = level_reg;

endmodule : eip_irq_lane

`default_nettype wire

/* File: tb_extended_irq_priority_sfrs.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_extended_irq_priority_sfrs;
    import eip_pkg::*;

    logic clk_i, rst_i, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] src_req, irq_req;
    logic [11:0] irq_level;
    logic [7:0] pin, p0_data, p0_off, acc, acc2;
    int mismatches, total_checks;

    eip_sfr_bank dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(hresp),
        .src_req_i(src_req), .irq_req_o(irq_req), .irq_level_o(irq_level),
        .port0_pin_i(pin), .port0_data_o(p0_data),
        .port0_input_off_o(p0_off), .acc_o(acc), .second_acc_o(acc2));

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte address of a register index
    function automatic logic [31:0] adr(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction : adr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // One single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(hresp, HRESP_OKAY, "response");
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, {24'h0, d}, r);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e,
                          input string what);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(r, {24'h0, e}, what);
    endtask : rd_chk

    // Let n edges pass, then look once outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // Scenarios

    // Everything reads zero out of reset, outputs idle
    task automatic t_reset_values();
        rd_chk(adr(IDX_ACC), REG_RST, "acc reset");
        rd_chk(adr(IDX_ENABLE), REG_RST, "enable reset");
        rd_chk(adr(IDX_SECOND_ACC), REG_RST, "second acc reset");
        rd_chk(adr(IDX_P0_OFF), REG_RST, "p0 off reset");
        rd_chk(adr(IDX_TOP_PRIO), REG_RST, "top prio reset");
        rd_chk(adr(IDX_PRIO), REG_RST, "prio reset");
        chk(irq_level, 12'h0, "level reset");
        chk(irq_req, 6'h0, "req reset");
    endtask : t_reset_values

    // Plain storage, then stray addresses that must change nothing
    task automatic t_storage();
        wr(adr(IDX_ACC), 8'ha5);
        wr(adr(IDX_SECOND_ACC), 8'h5a);
        rd_chk(adr(IDX_ACC), 8'ha5, "acc rw");
        rd_chk(adr(IDX_SECOND_ACC), 8'h5a, "second acc rw");
        chk(acc, 8'ha5, "acc out");
        chk(acc2, 8'h5a, "second acc out");
        wr(32'h400 | adr(IDX_ACC), 8'h11);
        wr(adr(8'h10), 8'h22);
        rd_chk(adr(8'h10), 8'h00, "unmapped read");
        rd_chk(32'h400 | adr(IDX_ACC), 8'h00, "high address read");
        rd_chk(adr(IDX_ACC), 8'ha5, "acc after stray");
    endtask : t_storage

    // Each disable bit blanks exactly its own pin
    task automatic t_port0();
        @(posedge clk_i);
        pin <= 8'hff;
        wr(adr(IDX_P0_OFF), 8'ha5);
        settle(2);
        chk(p0_off, 8'ha5, "p0 off out");
        chk(p0_data, 8'h5a, "p0 data gated");
        @(posedge clk_i);
        pin <= 8'h3c;
        settle(2);
        chk(p0_data, 8'h18, "p0 data follows pin");
        rd_chk(adr(IDX_P0_OFF), 8'ha5, "p0 off read");
    endtask : t_port0

    // Walk one bit through each priority register, then a mixed pattern
    task automatic t_priority();
        logic [11:0] e;
        for (int k = 0; k < 6; k++) begin
            wr(adr(IDX_TOP_PRIO), 8'h01 << k);
            wr(adr(IDX_PRIO), 8'h00);
            settle(2);
            e = 12'h1 << (2 * k + 1);
            chk(irq_level, e, "top level");
            wr(adr(IDX_TOP_PRIO), 8'h00);
            wr(adr(IDX_PRIO), 8'h01 << k);
            settle(2);
            e = 12'h1 << (2 * k);
            chk(irq_level, e, "high level");
        end
        wr(adr(IDX_TOP_PRIO), 8'hea);
        wr(adr(IDX_PRIO), 8'hd5);
        settle(2);
        chk(irq_level, 12'h999, "mixed levels");
        rd_chk(adr(IDX_TOP_PRIO), 8'h2a, "top reserved");
        rd_chk(adr(IDX_PRIO), 8'h15, "prio reserved");
    endtask : t_priority

    // Requests pass only through set enable bits
    task automatic t_enable();
        @(posedge clk_i);
        src_req <= 6'h3f;
        for (int k = 0; k < 6; k++) begin
            wr(adr(IDX_ENABLE), 8'h01 << k);
            settle(2);
            chk(irq_req, 6'h01 << k, "single enable");
        end
        wr(adr(IDX_ENABLE), 8'hff);
        rd_chk(adr(IDX_ENABLE), 8'h3f, "enable reserved");
        wr(adr(IDX_PENDING), 8'h00);
        rd_chk(adr(IDX_PENDING), 8'h3f, "pending status");
        @(posedge clk_i);
        src_req <= 6'h12;
        settle(2);
        chk(irq_req, 6'h12, "req follows source");
        wr(adr(IDX_ENABLE), 8'h02);
        settle(2);
        chk(irq_req, 6'h02, "req masked");
    endtask : t_enable

    // Second reset in mid-run clears everything again
    task automatic t_reset_again();
        @(posedge clk_i);
        rst_i <= 1'b1;
        settle(2);
        chk(irq_req, 6'h0, "req in reset");
        chk(acc, 8'h0, "acc in reset");
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
    endtask : t_reset_again

    ////////////////////////////////////////////////////////////////////////
    // Verdict, clock, watchdog, main sequence

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end

    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        src_req = 6'h0;
        pin = 8'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_storage();
        t_port0();
        t_priority();
        t_enable();
        t_reset_again();
        end_of_test();
    end

endmodule : tb_extended_irq_priority_sfrs

`default_nettype wire
